// file: hw/cxf_ctrl.v
/*
  fail-safe and mode control of a high-speed can transceiver, with an
  ahb-lite register slave and a level interrupt.
  assumes: undriven pins are pulled high at the pad (txd, stby);
  supply and thermal flags come from analog comparators, asynchronous.
*/
// Our own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "cxf_consts.vh"

module cxf_ctrl #(
  parameter CW = 20,
  parameter [CW-1:0] TXTO_CYC = `CXF_TXTO_DEF,
  parameter [CW-1:0] BUSTO_CYC = `CXF_BUSTO_DEF,
  parameter [CW-1:0] WAKE_CYC = `CXF_WAKE_DEF
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  output reg irq,
  input wire txd_pin,
  input wire standby_select,
  input wire bus_dominant,
  input wire core_supply_low,
  input wire io_supply_low,
  input wire over_temp,
  output reg drive_dominant,
  output reg tx_enable,
  output reg rx_normal_enable,
  output reg bus_bias_enable,
  output reg rxd,
  output reg split_enable
);
  localparam M_OFF = 3'b001;
  localparam M_STBY = 3'b010;
  localparam M_NORM = 3'b100;

  wire [5:0] sync_out;
  wire txd_s;
  wire stb_s;
  wire bus_s;
  wire uvc_s;
  wire uvio_s;
  wire ot_s;

  // pins idle high, comparators idle inactive
  cxf_sync #(.WIDTH(6), .INIT(6'h03)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .din({over_temp, io_supply_low, core_supply_low, bus_dominant,
          standby_select, txd_pin}),
    .dout(sync_out)
  );
  assign txd_s = sync_out[0];
  assign stb_s = sync_out[1];
  assign bus_s = sync_out[2];
  assign uvc_s = sync_out[3];
  assign uvio_s = sync_out[4];
  assign ot_s = sync_out[5];

  reg [2:0] mode;
  reg [2:0] next_mode;
  reg [1:0] ctrl;
  reg [CW-1:0] txto_lim;
  reg [CW-1:0] busto_lim;
  reg [CW-1:0] wake_lim;
  reg [CW-1:0] tx_cnt;
  reg [CW-1:0] bus_cnt;
  reg [CW-1:0] flt_cnt;
  reg tx_to;
  reg bus_to;
  reg ot_latch;
  reg bus_q;
  reg flt_state;
  reg [`CXF_NEV-1:0] irq_stat;
  reg [`CXF_NEV-1:0] irq_en;
  reg uvc_q;
  reg uvio_q;
  reg wake_q;

  // software may override either pin toward the safe high level only
  wire eff_txd = txd_s | ctrl[`CXF_CTRL_TXD];
  wire eff_stb = stb_s | ctrl[`CXF_CTRL_STBY];
  wire in_norm = (mode == M_NORM);
  wire in_stby = (mode == M_STBY);

  // mode selection; wake-up alone never changes mode
  always @* begin
    case (mode)
      M_OFF: next_mode = M_STBY;
      M_STBY: next_mode = eff_stb ? M_STBY : M_NORM;
      M_NORM: next_mode = eff_stb ? M_STBY : M_NORM;
      default: next_mode = M_OFF;
    endcase
    if (uvc_s) begin
      next_mode = M_STBY;
    end
    if (uvio_s) begin
      next_mode = M_OFF;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode <= M_OFF;
    end else begin
      mode <= next_mode;
    end
  end

  // transmit-dominant timer; saturates once tripped
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_cnt <= {CW{1'b0}};
      tx_to <= 1'b0;
    end else if (eff_txd) begin
      tx_cnt <= {CW{1'b0}};
      tx_to <= 1'b0;
    end else if (tx_cnt >= txto_lim) begin
      tx_to <= 1'b1;
    end else begin
      tx_cnt <= tx_cnt + 1'b1;
    end
  end

  // driver shutdown holds until cool and transmit recessive
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ot_latch <= 1'b0;
    end else if (ot_s) begin
      ot_latch <= 1'b1;
    end else if (eff_txd) begin
      ot_latch <= 1'b0;
    end
  end

  // standby bus-dominant timer and wake filter
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_q <= 1'b0;
      bus_cnt <= {CW{1'b0}};
      bus_to <= 1'b0;
      flt_cnt <= {CW{1'b0}};
      flt_state <= 1'b0;
    end else begin
      bus_q <= bus_s;
      if (!in_stby) begin
        bus_cnt <= {CW{1'b0}};
        bus_to <= 1'b0;
      end else if (!bus_s) begin
        bus_cnt <= {CW{1'b0}};
        // timeout holds until the filtered state is recessive too, so a
        // released clamp does not read as a short fresh wake-up
        if (!flt_state) begin
          bus_to <= 1'b0;
        end
      end else if (!bus_q) begin
        bus_cnt <= {CW{1'b0}};
      end else if (bus_cnt >= busto_lim) begin
        bus_to <= 1'b1;
      end else begin
        bus_cnt <= bus_cnt + 1'b1;
      end
      // filter follows states in both directions, never latching
      // no stale filtered state may survive into the next standby phase
      if (!in_stby) begin
        flt_cnt <= {CW{1'b0}};
        flt_state <= 1'b0;
      end else if (bus_s == flt_state) begin
        flt_cnt <= {CW{1'b0}};
      end else if (flt_cnt >= wake_lim) begin
        flt_state <= bus_s;
        flt_cnt <= {CW{1'b0}};
      end else begin
        flt_cnt <= flt_cnt + 1'b1;
      end
    end
  end

  wire wake = in_stby & flt_state & ~bus_to;
  wire drv_ok = in_norm & ~tx_to & ~ot_latch;

  // pin outputs, all registered
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drive_dominant <= 1'b0;
      tx_enable <= 1'b0;
      rx_normal_enable <= 1'b0;
      bus_bias_enable <= 1'b0;
      rxd <= 1'b1;
      split_enable <= 1'b0;
    end else begin
      tx_enable <= drv_ok;
      drive_dominant <= drv_ok & ~eff_txd;
      rx_normal_enable <= in_norm;
      bus_bias_enable <= ~(mode == M_OFF);
      split_enable <= in_norm & ~uvc_s;
      if (in_norm) begin
        rxd <= ~bus_s;
      end else begin
        rxd <= ~wake;
      end
    end
  end

  // interrupt events, set beats clear
  wire [`CXF_NEV-1:0] ev;
  assign ev[`CXF_EV_TXTO] = ~eff_txd & (tx_cnt >= txto_lim) & ~tx_to;
  assign ev[`CXF_EV_BUSTO] = in_stby & bus_s & bus_q &
    (bus_cnt >= busto_lim) & ~bus_to;
  assign ev[`CXF_EV_OT] = ot_s & ~ot_latch;
  assign ev[`CXF_EV_UVC] = uvc_s & ~uvc_q;
  assign ev[`CXF_EV_UVIO] = uvio_s & ~uvio_q;
  assign ev[`CXF_EV_WAKE] = wake & ~wake_q;

  // ahb-lite slave: zero wait states, write data taken in data phase
  reg wr_pend;
  reg [7:0] wr_addr;
  wire acc = hsel & hready & htrans[1];
  wire [`CXF_NEV-1:0] clr_mask = (wr_pend && wr_addr == `CXF_REG_IRQ_CLR) ?
    hwdata[`CXF_NEV-1:0] : {`CXF_NEV{1'b0}};

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      uvc_q <= 1'b0;
      uvio_q <= 1'b0;
      wake_q <= 1'b0;
      irq_stat <= {`CXF_NEV{1'b0}};
      irq <= 1'b0;
    end else begin
      uvc_q <= uvc_s;
      uvio_q <= uvio_s;
      wake_q <= wake;
      irq_stat <= (irq_stat & ~clr_mask) | ev;
      irq <= |(((irq_stat & ~clr_mask) | ev) & irq_en);
    end
  end

  wire [31:0] status = {22'h000000, wake, split_enable, rxd, uvio_s, uvc_s,
    ot_latch, bus_to, tx_to, ~tx_enable, in_stby};

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      ctrl <= `CXF_CTRL_RESET;
      irq_en <= {`CXF_NEV{1'b0}};
      txto_lim <= TXTO_CYC;
      busto_lim <= BUSTO_CYC;
      wake_lim <= WAKE_CYC;
    end else begin
      wr_pend <= acc & hwrite;
      wr_addr <= haddr[7:0];
      if (wr_pend) begin
        case (wr_addr)
          `CXF_REG_CTRL: ctrl <= hwdata[1:0];
          `CXF_REG_IRQ_EN: irq_en <= hwdata[`CXF_NEV-1:0];
          `CXF_REG_TXTO: txto_lim <= hwdata[CW-1:0];
          `CXF_REG_BUSTO: busto_lim <= hwdata[CW-1:0];
          `CXF_REG_WAKE: wake_lim <= hwdata[CW-1:0];
          default: ;
        endcase
      end
      if (acc && !hwrite) begin
        case (haddr[7:0])
          `CXF_REG_CTRL: hrdata <= {30'h00000000, ctrl};
          `CXF_REG_STAT: hrdata <= status;
          `CXF_REG_IRQ_STAT: hrdata <= {26'h0000000, irq_stat};
          `CXF_REG_IRQ_EN: hrdata <= {26'h0000000, irq_en};
          `CXF_REG_TXTO: hrdata <= {{(32-CW){1'b0}}, txto_lim};
          `CXF_REG_BUSTO: hrdata <= {{(32-CW){1'b0}}, busto_lim};
          `CXF_REG_WAKE: hrdata <= {{(32-CW){1'b0}}, wake_lim};
          default: hrdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // cxf_ctrl

// file: hw/cxf_sync.v
/*
  two flip-flop synchroniser for a group of asynchronous level inputs.
  assumes inputs come from pins or analog comparators outside hclk.
*/
`timescale 1ns/1ps
module cxf_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input wire hclk,
  input wire hresetn,
  input wire [WIDTH-1:0] din,
  output reg [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] meta;

  // meta feeds only dout
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta <= INIT;
      dout <= INIT;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // cxf_sync

// file: include/cxf_consts.vh
/*
  constants for the transceiver fail-safe controller: register offsets,
  field positions, reset values and default timing counts.
  assumes inclusion by bare name from the design files.
*/
`ifndef CXF_CONSTS_VH
`define CXF_CONSTS_VH

// register byte offsets
`define CXF_REG_CTRL 8'h00
`define CXF_REG_STAT 8'h04
`define CXF_REG_IRQ_STAT 8'h08
`define CXF_REG_IRQ_CLR 8'h0C
`define CXF_REG_IRQ_EN 8'h10
`define CXF_REG_TXTO 8'h14
`define CXF_REG_BUSTO 8'h18
`define CXF_REG_WAKE 8'h1C

// control register fields
`define CXF_CTRL_STBY 0
`define CXF_CTRL_TXD 1
`define CXF_CTRL_RESET 2'h3

// status register fields
`define CXF_ST_STBY 0
`define CXF_ST_TXOFF 1
`define CXF_ST_TXTO 2
`define CXF_ST_BUSTO 3
`define CXF_ST_OT 4
`define CXF_ST_UVC 5
`define CXF_ST_UVIO 6
`define CXF_ST_RXD 7
`define CXF_ST_SPLIT 8
`define CXF_ST_WAKE 9

// interrupt event bits
`define CXF_EV_TXTO 0
`define CXF_EV_BUSTO 1
`define CXF_EV_OT 2
`define CXF_EV_UVC 3
`define CXF_EV_UVIO 4
`define CXF_EV_WAKE 5
`define CXF_NEV 6

// default timing counts in hclk cycles
`define CXF_TXTO_DEF 20'h186A0
`define CXF_BUSTO_DEF 20'h186A0
`define CXF_WAKE_DEF 20'h00032

// ahb transfer type
`define CXF_HTRANS_NONSEQ 2'h2

`endif

// file: verif/cxf_ctrl_properties.sv
/* assertions on the control block's pins
   assumes the timing registers keep their reset values */
`timescale 1ns/1ps
module cxf_ctrl_properties #(
  parameter CW = 20,
  parameter [CW-1:0] TXTO_CYC = 20,
  parameter [CW-1:0] BUSTO_CYC = 20,
  parameter [CW-1:0] WAKE_CYC = 4
) (
  input wire hclk,
  input wire hresetn,
  input wire txd_pin,
  input wire standby_select,
  input wire bus_dominant,
  input wire core_supply_low,
  input wire io_supply_low,
  input wire over_temp,
  input wire drive_dominant,
  input wire tx_enable,
  input wire rx_normal_enable,
  input wire bus_bias_enable,
  input wire rxd,
  input wire split_enable
);
  reg [7:0] tx_low;
  reg [7:0] bus_hi;
  // run lengths wrap after 256 cycles, longer than any hold in the bench
  always @(posedge hclk or negedge hresetn)
    if (!hresetn) tx_low <= 8'h00;
    else tx_low <= txd_pin ? 8'h00 : tx_low + 8'h01;
  always @(posedge hclk or negedge hresetn)
    if (!hresetn) bus_hi <= 8'h00;
    else bus_hi <= (bus_dominant & ~rx_normal_enable) ?
      bus_hi + 8'h01 : 8'h00;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  io_off_a: assert property (io_supply_low [*4] |=>
    !bus_bias_enable && !tx_enable && !split_enable) else $error("io off");
  core_uv_a: assert property (core_supply_low [*4] |=>
    !rx_normal_enable && !split_enable) else $error("core uv mode");
  stby_mode_a: assert property (standby_select [*4] |=>
    !rx_normal_enable && !tx_enable) else $error("standby mode");
  ot_off_a: assert property (over_temp [*4] |=>
    !tx_enable && !drive_dominant) else $error("overtemp drive");
  tx_timeout_a: assert property (tx_low > TXTO_CYC + 6 |->
    !drive_dominant) else $error("tx timeout missed");
  drive_src_a: assert property (drive_dominant |->
    tx_enable && !$past(txd_pin, 3)) else $error("drive source");
  rx_normal_a: assert property (rx_normal_enable [*5] |->
    rxd == !$past(bus_dominant, 3)) else $error("rxd in normal");
  bus_timeout_a: assert property (bus_hi > BUSTO_CYC + WAKE_CYC + 8
    |-> rxd) else $error("bus timeout missed");
  split_mode_a: assert property (split_enable ==
    (rx_normal_enable && !$past(core_supply_low, 3)))
    else $error("split mode");
  cover property (!tx_enable && rx_normal_enable);
  cover property (!rx_normal_enable && $fell(rxd));
  cover property ($fell(bus_bias_enable));
endmodule // cxf_ctrl_properties
bind cxf_ctrl cxf_ctrl_properties #(.CW(CW), .TXTO_CYC(TXTO_CYC),
  .BUSTO_CYC(BUSTO_CYC), .WAKE_CYC(WAKE_CYC)) chk_u (
  .hclk(hclk),
  .hresetn(hresetn),
  .txd_pin(txd_pin),
  .standby_select(standby_select),
  .bus_dominant(bus_dominant),
  .core_supply_low(core_supply_low),
  .io_supply_low(io_supply_low),
  .over_temp(over_temp),
  .drive_dominant(drive_dominant),
  .tx_enable(tx_enable),
  .rx_normal_enable(rx_normal_enable),
  .bus_bias_enable(bus_bias_enable),
  .rxd(rxd),
  .split_enable(split_enable)
);

// file: verif/cxf_host.sv
/* host controller model: serial transmit data and standby select
   assumes frames are only requested in normal mode */
`timescale 1ns/1ps
module cxf_host (
  input wire hclk,
  input wire normal_req,
  input wire stuck_low,
  input wire send,
  input wire [15:0] frame,
  output reg txd_pin,
  output reg standby_select
);
  reg [15:0] sh = 16'h0000;
  reg [5:0] left = 6'h00;
  initial txd_pin = 1'b1;
  initial standby_select = 1'b1;
  // four cycles a bit keeps low runs far below the timeout
  always @(posedge hclk) begin
    standby_select <= !normal_req;
    txd_pin <= stuck_low ? 1'b0 : (left == 6'h00 || sh[left[5:2]]);
    if (send) begin
      sh <= frame;
      left <= 6'h3F;
    end else if (left != 6'h00)
      left <= left - 6'h01;
  end
endmodule // cxf_host

// file: verif/tb_can_transceiver_failsafe_ctrl.sv
/* bench for the control block: ahb master, host model on the pins,
   bus looped back from the driver unless a scenario owns it */
`timescale 1ns/1ps
`include "cxf_consts.vh"
module tb_can_transceiver_failsafe_ctrl;
  reg hclk, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, send = 1'b0;
  reg normal_req = 1'b0, stuck_low = 1'b0, loop = 1'b1, bus_val = 1'b0;
  reg bus_dominant = 1'b0, core_supply_low = 1'b0, io_supply_low = 1'b0;
  reg over_temp = 1'b0;
  reg [1:0] htrans = 2'h0;
  reg [15:0] frame = 16'h0000;
  reg [31:0] haddr = 32'h0, hwdata = 32'h0, rd, rv;
  wire [31:0] hrdata;
  wire hreadyout, hresp, irq, txd_pin, standby_select, drive_dominant;
  wire tx_enable, rx_normal_enable, bus_bias_enable, rxd, split_enable;
  integer err_total = 0, n_compared = 0, seed = 66, i, t;
  cxf_ctrl #(.TXTO_CYC(20'h14), .BUSTO_CYC(20'h14), .WAKE_CYC(20'h4))
    dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .irq(irq), .txd_pin(txd_pin),
    .standby_select(standby_select), .bus_dominant(bus_dominant),
    .core_supply_low(core_supply_low), .io_supply_low(io_supply_low),
    .over_temp(over_temp), .drive_dominant(drive_dominant),
    .tx_enable(tx_enable), .rx_normal_enable(rx_normal_enable),
    .bus_bias_enable(bus_bias_enable), .rxd(rxd),
    .split_enable(split_enable));
  cxf_host host_u (.hclk(hclk), .normal_req(normal_req),
    .stuck_low(stuck_low), .send(send), .frame(frame), .txd_pin(txd_pin),
    .standby_select(standby_select));
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  always @(posedge hclk) bus_dominant <= loop ? drive_dominant : bus_val;
  task report_and_stop;
    begin
      $display("compared %0d, mismatched %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge hclk);
  endtask
  function [31:0] rst_val(input [7:0] a);
    case (a)
      `CXF_REG_CTRL: rst_val = `CXF_CTRL_RESET;
      `CXF_REG_TXTO, `CXF_REG_BUSTO: rst_val = 32'h14;
      `CXF_REG_WAKE: rst_val = 32'h4;
      default: rst_val = 32'h0;
    endcase
  endfunction
  task ahb(input [7:0] a, input w, input [31:0] d);
    integer k;
    begin
      hsel <= 1'b1;
      htrans <= `CXF_HTRANS_NONSEQ;
      haddr <= {24'h000000, a};
      hwrite <= w;
      for (k = 0; k < 2; k = k + 1) begin
        t = 1;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && t < 40) begin
          @(posedge hclk);
          t = t + 1;
        end
        if (hreadyout !== 1'b1) begin
          err_total = err_total + 1;
          report_and_stop;
        end
        if (k == 0) begin
          hsel <= 1'b0;
          htrans <= 2'h0;
          hwdata <= d;
        end
      end
      rd = hrdata;
    end
  endtask
  initial begin
    cyc(10);
    hresetn <= 1'b1;
    for (i = 0; i <= 64; i = i + 4) begin
      ahb(i[7:0], 1'b0, 32'h0);
      if (i != 4 && i != 12) chk(rd, rst_val(i[7:0]));
    end
    rv = $random(seed);
    ahb(`CXF_REG_WAKE, 1'b1, rv);
    ahb(`CXF_REG_WAKE, 1'b0, 32'h0);
    chk(rd, rv & 32'h000FFFFF);
    chk(hresp, 32'h0);
    ahb(`CXF_REG_WAKE, 1'b1, 32'h00000004);
    chk({rx_normal_enable, rxd}, 32'h1);
    ahb(`CXF_REG_CTRL, 1'b1, 32'h0);
    normal_req <= 1'b1;
    cyc(6);
    chk({rx_normal_enable, split_enable, tx_enable}, 32'h7);
    for (i = 0; i < 6; i = i + 1) begin
      frame <= (i == 0) ? 16'h1111 : 16'h1111 | 16'($random(seed));
      send <= 1'b1;
      cyc(1);
      send <= 1'b0;
      cyc(70);
    end
    ahb(`CXF_REG_STAT, 1'b0, 32'h0);
    chk(rd[`CXF_ST_TXTO], 32'h0);
    ahb(`CXF_REG_IRQ_EN, 1'b1, 32'h1);
    stuck_low <= 1'b1;
    cyc(10);
    chk(drive_dominant, 32'h1);
    cyc(20);
    chk({irq, tx_enable, drive_dominant}, 32'h4);
    stuck_low <= 1'b0;
    ahb(`CXF_REG_IRQ_EN, 1'b1, 32'h0);
    cyc(4);
    chk({irq, tx_enable}, 32'h1);
    ahb(`CXF_REG_IRQ_CLR, 1'b1, 32'h3F);
    ahb(`CXF_REG_IRQ_STAT, 1'b0, 32'h0);
    chk(rd, 32'h0);
    over_temp <= 1'b1;
    stuck_low <= 1'b1;
    cyc(5);
    chk(tx_enable, 32'h0);
    over_temp <= 1'b0;
    cyc(8);
    chk(tx_enable, 32'h0);
    stuck_low <= 1'b0;
    cyc(6);
    chk(tx_enable, 32'h1);
    core_supply_low <= 1'b1;
    cyc(5);
    chk({rx_normal_enable, split_enable}, 32'h0);
    core_supply_low <= 1'b0;
    io_supply_low <= 1'b1;
    cyc(5);
    chk({bus_bias_enable, tx_enable}, 32'h0);
    io_supply_low <= 1'b0;
    cyc(6);
    chk({bus_bias_enable, rx_normal_enable}, 32'h3);
    normal_req <= 1'b0;
    loop <= 1'b0;
    cyc(5);
    bus_val <= 1'b1;
    cyc(2);
    bus_val <= 1'b0;
    cyc(8);
    chk({split_enable, rxd}, 32'h1);
    bus_val <= 1'b1;
    cyc(12);
    chk({rxd, rx_normal_enable}, 32'h0);
    cyc(25);
    chk(rxd, 32'h1);
    bus_val <= 1'b0;
    cyc(10);
    bus_val <= 1'b1;
    cyc(12);
    chk(rxd, 32'h0);
    report_and_stop;
  end
endmodule // tb_can_transceiver_failsafe_ctrl
